// >>> core/ttm_pkg.sv
// Shared constants and types of the transaction timer manager
package ttm_pkg;

	// Timer count; slot 5 exists but is never used
	localparam int NUM_TIMERS = 7;

	// Register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h60;
	localparam logic [7:0] ADDR_HI_OFS = 8'h64;
	localparam logic [7:0] ADDR_LO_OFS = 8'h68;
	localparam logic [7:0] ATTR_OFS = 8'h6C;
	localparam logic [7:0] IRQ_STAT_OFS = 8'h70;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h74;

	// Control field positions, counted from the lsb
	localparam int DONE_TOP = 31;
	localparam int FAIL_TOP = 23;
	localparam int RETRY_TOP = 15;
	localparam int SEL_LSB = 4;
	localparam int CANCEL_BIT = 3;
	localparam int SUSPEND_BIT = 2;
	localparam int RESUME_BIT = 1;

	// Timer numbers
	localparam logic [2:0] TMR_DATA_TX = 3'h0;
	localparam logic [2:0] TMR_DATA_RX = 3'h1;
	localparam logic [2:0] TMR_ASYNC_TX = 3'h2;
	localparam logic [2:0] TMR_MGMT = 3'h3;
	localparam logic [2:0] TMR_COMMAND = 3'h4;
	localparam logic [2:0] TMR_UNUSED = 3'h5;
	localparam logic [2:0] TMR_AUTO_RESP = 3'h6;

	// Speed codes
	localparam logic [1:0] SPD_100 = 2'h0;
	localparam logic [1:0] SPD_200 = 2'h1;
	localparam logic [1:0] SPD_400 = 2'h2;

	// Completion status codes of response entries
	localparam logic [3:0] ST_OK = 4'h0;
	localparam logic [3:0] ST_ACK_ERR = 4'h2;
	localparam logic [3:0] ST_RETRY_LIMIT = 4'h7;
	localparam logic [3:0] ST_RCODE_ERR = 4'hA;
	localparam logic [3:0] ST_SPLIT_TIMEOUT = 4'hB;

	// Timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int SPLIT_TIME_NS = 100000;
	localparam int SPLIT_CYCLES_DEF = SPLIT_TIME_NS / CLK_PERIOD_NS;
	localparam logic [3:0] RETRY_LIMIT_DEF = 4'h3;
	localparam logic [15:0] SPLIT_VIEW_MAX = 16'h3FFF;

	// Bus answers
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	typedef enum logic [2:0] {T_IDLE, T_SEND, T_WAIT_ACK, T_SPLIT, T_HELD} timer_state_type;
	typedef enum logic [2:0] {
		EV_ACK_DONE, EV_ACK_BUSY, EV_ACK_PEND, EV_ACK_ERR, EV_RESP_OK, EV_RESP_ERR, EV_BUS_RESET
	} event_kind_type;

	typedef struct packed {
		logic [15:0] dest_id;
		logic [15:0] off_hi;
		logic [31:0] off_lo;
		logic [3:0] tcode;
		logic [1:0] spd;
		logic [5:0] tlabel;
	} header_type;

	typedef struct packed {logic valid; logic [2:0] timer; header_type hdr;} tx_request_type;
	typedef struct packed {logic valid; logic [2:0] timer; event_kind_type kind;} link_event_type;
	typedef struct packed {logic valid; logic [2:0] timer; header_type hdr;} send_type;
	typedef struct packed {logic valid; logic [2:0] timer; logic [3:0] status; logic dummy;} resp_entry_type;

	typedef struct packed {
		timer_state_type fsm;
		logic failed;
		logic [3:0] retries;
		logic [15:0] split;
		header_type hdr;
	} slot_type;

	typedef struct packed {
		slot_type [NUM_TIMERS-1:0] slots;
		logic [2:0] sel;
		logic [NUM_TIMERS-1:0] irq_stat;
		logic [NUM_TIMERS-1:0] irq_mask;
		logic irq;
		send_type send;
		resp_entry_type resp;
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_type;

endpackage

// >>> core/transaction_timer_manager.sv
// Transaction timer manager: per-queue timers, selected-timer view, AXI4-Lite registers
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Every queue's transaction runs under own timer
// - Done flag low while transaction runs
// - Fail flag marks last transaction ended badly
// - Each completed request writes response entry
// - Retry exhaustion or split timeout writes substitute
// - Aborted or bus-reset transactions write nothing
// - Retry flag set while transmitting or retrying
// - Retry clear, not done, means split wait
// - Timer select picks timer for status view
// - Timer numbers fixed; number five unused
// - Status shows address, code, speed, label, counters
// - Cancel bit aborts the selected transaction
// - Suspend bit holds the selected transaction unless it is in split wait
// - Resume bit restarts a held transaction
// - Speed codes 100, 200, 400 Mbps
module transaction_timer_manager #(
	parameter int SPLIT_CYCLES = ttm_pkg::SPLIT_CYCLES_DEF,
	parameter logic [3:0] RETRY_LIMIT = ttm_pkg::RETRY_LIMIT_DEF
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire ttm_pkg::tx_request_type tx_req,
	input wire ttm_pkg::link_event_type link_evt,
	output ttm_pkg::send_type send,
	output ttm_pkg::resp_entry_type resp,
	output logic irq
);

	localparam int NT = ttm_pkg::NUM_TIMERS;

	logic [1:0] rst_sync_reg; // Reset release synchroniser
	logic rst_n; // Synchronised reset
	ttm_pkg::state_type st_reg; // All block state
	ttm_pkg::state_type st_next; // Next value of state
	logic resp_busy; // Response port already taken this cycle
	logic send_busy; // Send port already taken this cycle
	logic [2:0] t; // Timer named by the link event
	logic [2:0] ws; // Timer named by a control write
	logic do_write; // Both write halves present
	logic [NT-1:0] cancel_hit; // Abort request per timer
	logic [NT-1:0] suspend_hit; // Hold request per timer
	logic [NT-1:0] resume_hit; // Release request per timer
	logic [NT-1:0] retry_flag; // Transmitting or retrying
	logic [31:0] rd; // Read data being assembled
	ttm_pkg::slot_type view; // Slot picked by the select field

	// Ends a transaction, leaving the fail flag as given
	function automatic ttm_pkg::slot_type finish(ttm_pkg::slot_type s, logic f);
		s.fsm = ttm_pkg::T_IDLE;
		s.failed = f;
		return s;
	endfunction

	// Builds one response entry
	function automatic ttm_pkg::resp_entry_type entry(logic [2:0] tm, logic [3:0] code, logic d);
		ttm_pkg::resp_entry_type e;
		e.valid = 1'h1;
		e.timer = tm;
		e.status = code;
		e.dummy = d;
		return e;
	endfunction

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'h1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// Next-state logic of bus slave, timers and interrupt
	always_comb begin
		st_next = st_reg;
		resp_busy = 1'h0;
		send_busy = 1'h0;
		t = link_evt.timer;
		ws = st_reg.wdata[ttm_pkg::SEL_LSB +: 3];
		rd = 32'h0000_0000;
		cancel_hit = '0;
		suspend_hit = '0;
		resume_hit = '0;
		st_next.send.valid = 1'h0;
		st_next.resp = '0;
		view = (st_reg.sel < 3'(NT)) ? st_reg.slots[st_reg.sel] : '0;
		// Retry flag covers the whole transmit phase, so split wait is the only busy state without it
		for (int i = 0; i < NT; i++) begin
			retry_flag[i] = st_reg.slots[i].fsm inside {ttm_pkg::T_SEND, ttm_pkg::T_WAIT_ACK,
				ttm_pkg::T_HELD};
		end

		// Write channel: address and data may come in either order
		do_write = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
		if (awvalid && st_reg.awready) begin
			st_next.aw_got = 1'h1;
			st_next.aw_addr = awaddr;
		end
		if (wvalid && st_reg.wready) begin
			st_next.w_got = 1'h1;
			st_next.wdata = wdata;
			st_next.wstrb = wstrb;
		end
		if (bready && st_reg.bvalid) begin
			st_next.bvalid = 1'h0;
		end
		if (do_write) begin
			st_next.aw_got = 1'h0;
			st_next.w_got = 1'h0;
			st_next.bvalid = 1'h1;
			st_next.bresp = ttm_pkg::AXI_OKAY;
			case (st_reg.aw_addr)
				ttm_pkg::CTRL_OFS: begin
					// Select and action bits all sit in byte lane 0
					if (st_reg.wstrb[0]) begin
						st_next.sel = ws;
						// Action bits act on the timer named in the same write
						if (ws < 3'(NT) && ws != ttm_pkg::TMR_UNUSED) begin
							cancel_hit[ws] = st_reg.wdata[ttm_pkg::CANCEL_BIT];
							suspend_hit[ws] = st_reg.wdata[ttm_pkg::SUSPEND_BIT];
							resume_hit[ws] = st_reg.wdata[ttm_pkg::RESUME_BIT];
						end
					end
				end
				ttm_pkg::IRQ_MASK_OFS: begin
					if (st_reg.wstrb[0]) begin
						st_next.irq_mask = st_reg.wdata[NT-1:0];
					end
				end
				ttm_pkg::ADDR_HI_OFS, ttm_pkg::ADDR_LO_OFS, ttm_pkg::ATTR_OFS,
				ttm_pkg::IRQ_STAT_OFS: begin
					// Read-only words ignore writes
				end
				default: begin
					st_next.bresp = ttm_pkg::AXI_SLVERR;
				end
			endcase
		end

		// Read channel
		if (rready && st_reg.rvalid) begin
			st_next.rvalid = 1'h0;
		end
		if (arvalid && st_reg.arready) begin
			st_next.rvalid = 1'h1;
			st_next.rresp = ttm_pkg::AXI_OKAY;
			case (araddr)
				ttm_pkg::CTRL_OFS: begin
					// Timer i sits at msb-first bit i of each flag group; action bits read zero
					for (int i = 0; i < NT; i++) begin
						if (i != int'(ttm_pkg::TMR_UNUSED)) begin
							rd[ttm_pkg::DONE_TOP-i] = st_reg.slots[i].fsm == ttm_pkg::T_IDLE;
							rd[ttm_pkg::FAIL_TOP-i] = st_reg.slots[i].failed;
							rd[ttm_pkg::RETRY_TOP-i] = retry_flag[i];
						end
					end
					rd[ttm_pkg::SEL_LSB +: 3] = st_reg.sel;
				end
				ttm_pkg::ADDR_HI_OFS: begin
					rd = {view.hdr.dest_id, view.hdr.off_hi};
				end
				ttm_pkg::ADDR_LO_OFS: begin
					rd = view.hdr.off_lo;
				end
				ttm_pkg::ATTR_OFS: begin
					// Split count saturates in the 14-bit view field
					rd = {view.hdr.tcode, 1'h0, view.hdr.spd, 1'h0, view.hdr.tlabel, view.retries,
						(view.split > ttm_pkg::SPLIT_VIEW_MAX) ? ttm_pkg::SPLIT_VIEW_MAX[13:0] :
						view.split[13:0]};
				end
				ttm_pkg::IRQ_STAT_OFS: begin
					rd[NT-1:0] = st_reg.irq_stat;
					st_next.irq_stat = '0;
				end
				ttm_pkg::IRQ_MASK_OFS: begin
					rd[NT-1:0] = st_reg.irq_mask;
				end
				default: begin
					st_next.rresp = ttm_pkg::AXI_SLVERR;
				end
			endcase
			st_next.rdata = rd;
		end

		// Link answers; a bus reset silently drops every transaction
		if (link_evt.valid && link_evt.kind == ttm_pkg::EV_BUS_RESET) begin
			for (int i = 0; i < NT; i++) begin
				st_next.slots[i].fsm = ttm_pkg::T_IDLE;
			end
		end else if (link_evt.valid && t < 3'(NT)) begin
			// Answers for a timer not waiting on them are stale and dropped
			unique case (link_evt.kind)
				ttm_pkg::EV_ACK_DONE: begin
					if (st_reg.slots[t].fsm == ttm_pkg::T_WAIT_ACK) begin
						st_next.slots[t] = finish(st_next.slots[t], 1'h0);
						st_next.resp = entry(t, ttm_pkg::ST_OK, 1'h0);
						resp_busy = 1'h1;
					end
				end
				ttm_pkg::EV_ACK_BUSY: begin
					if (st_reg.slots[t].fsm == ttm_pkg::T_WAIT_ACK) begin
						if (st_reg.slots[t].retries == RETRY_LIMIT) begin
							st_next.slots[t] = finish(st_next.slots[t], 1'h1);
							st_next.resp = entry(t, ttm_pkg::ST_RETRY_LIMIT, 1'h1);
							resp_busy = 1'h1;
						end else begin
							st_next.slots[t].retries = st_reg.slots[t].retries + 4'h1;
							st_next.slots[t].fsm = ttm_pkg::T_SEND;
						end
					end
				end
				ttm_pkg::EV_ACK_PEND: begin
					if (st_reg.slots[t].fsm == ttm_pkg::T_WAIT_ACK) begin
						st_next.slots[t].fsm = ttm_pkg::T_SPLIT;
						st_next.slots[t].split = 16'h0000;
					end
				end
				ttm_pkg::EV_ACK_ERR: begin
					if (st_reg.slots[t].fsm == ttm_pkg::T_WAIT_ACK) begin
						st_next.slots[t] = finish(st_next.slots[t], 1'h1);
						st_next.resp = entry(t, ttm_pkg::ST_ACK_ERR, 1'h0);
						resp_busy = 1'h1;
					end
				end
				ttm_pkg::EV_RESP_OK: begin
					if (st_reg.slots[t].fsm == ttm_pkg::T_SPLIT) begin
						st_next.slots[t] = finish(st_next.slots[t], 1'h0);
						st_next.resp = entry(t, ttm_pkg::ST_OK, 1'h0);
						resp_busy = 1'h1;
					end
				end
				ttm_pkg::EV_RESP_ERR: begin
					if (st_reg.slots[t].fsm == ttm_pkg::T_SPLIT) begin
						st_next.slots[t] = finish(st_next.slots[t], 1'h1);
						st_next.resp = entry(t, ttm_pkg::ST_RCODE_ERR, 1'h0);
						resp_busy = 1'h1;
					end
				end
				default: begin
					// Unassigned kind code
				end
			endcase
		end

		// Host actions, then timeouts, sends and new starts, per timer
		for (int i = 0; i < NT; i++) begin
			if (cancel_hit[i]) begin
				st_next.slots[i].fsm = ttm_pkg::T_IDLE;
			end else if (suspend_hit[i] && st_next.slots[i].fsm inside {ttm_pkg::T_SEND,
				ttm_pkg::T_WAIT_ACK}) begin
				st_next.slots[i].fsm = ttm_pkg::T_HELD;
			end else if (resume_hit[i] && st_next.slots[i].fsm == ttm_pkg::T_HELD) begin
				st_next.slots[i].fsm = ttm_pkg::T_SEND;
			end
			// Split timer; a timeout that loses the response port waits a cycle at the limit
			if (st_reg.slots[i].fsm == ttm_pkg::T_SPLIT && st_next.slots[i].fsm == ttm_pkg::T_SPLIT) begin
				if (st_reg.slots[i].split < 16'(SPLIT_CYCLES)) begin
					st_next.slots[i].split = st_reg.slots[i].split + 16'h0001;
				end else if (!resp_busy) begin
					st_next.slots[i] = finish(st_next.slots[i], 1'h1);
					st_next.resp = entry(3'(i), ttm_pkg::ST_SPLIT_TIMEOUT, 1'h1);
					resp_busy = 1'h1;
				end
			end
			// Lowest timer number wins the link
			if (st_next.slots[i].fsm == ttm_pkg::T_SEND && st_reg.slots[i].fsm == ttm_pkg::T_SEND
				&& !send_busy) begin
				st_next.slots[i].fsm = ttm_pkg::T_WAIT_ACK;
				st_next.send.valid = 1'h1;
				st_next.send.timer = 3'(i);
				st_next.send.hdr = st_reg.slots[i].hdr;
				send_busy = 1'h1;
			end
			// A queued packet starts only on an idle, numbered timer
			if (tx_req.valid && tx_req.timer == 3'(i) && i != int'(ttm_pkg::TMR_UNUSED)
				&& st_reg.slots[i].fsm == ttm_pkg::T_IDLE) begin
				st_next.slots[i].fsm = ttm_pkg::T_SEND;
				st_next.slots[i].failed = 1'h0;
				st_next.slots[i].retries = 4'h0;
				st_next.slots[i].split = 16'h0000;
				st_next.slots[i].hdr = tx_req.hdr;
			end
			// Sticky end event; it wins over a clearing read in the same cycle
			if (st_reg.slots[i].fsm != ttm_pkg::T_IDLE && st_next.slots[i].fsm == ttm_pkg::T_IDLE) begin
				st_next.irq_stat[i] = 1'h1;
			end
		end

		st_next.awready = !st_next.aw_got && !st_next.bvalid;
		st_next.wready = !st_next.w_got && !st_next.bvalid;
		st_next.arready = !st_next.rvalid;
		st_next.irq = |(st_next.irq_stat & st_next.irq_mask);
	end

	// State register; everything idles after reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign awready = st_reg.awready;
	assign wready = st_reg.wready;
	assign bvalid = st_reg.bvalid;
	assign bresp = st_reg.bresp;
	assign arready = st_reg.arready;
	assign rvalid = st_reg.rvalid;
	assign rdata = st_reg.rdata;
	assign rresp = st_reg.rresp;
	assign send = st_reg.send;
	assign resp = st_reg.resp;
	assign irq = st_reg.irq;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// Idle timer 0 sends its packet two edges after the start
	AST_START_SENDS: assert property (
		tx_req.valid && tx_req.timer == ttm_pkg::TMR_DATA_TX && st_reg.slots[0].fsm == ttm_pkg::T_IDLE
		|-> ##2 send.valid && send.timer == ttm_pkg::TMR_DATA_TX)
		else $error("start did not send");

	// A started transaction reads busy the next cycle
	AST_DONE_LOW: assert property (
		tx_req.valid && tx_req.timer == ttm_pkg::TMR_COMMAND && st_reg.slots[4].fsm == ttm_pkg::T_IDLE
		|=> st_reg.slots[4].fsm != ttm_pkg::T_IDLE [*2])
		else $error("done flag not low while running");

	// Error acknowledge fails and ends the transaction with an entry
	AST_ACK_ERR: assert property (
		link_evt.valid && link_evt.kind == ttm_pkg::EV_ACK_ERR && link_evt.timer == 3'h0
		&& st_reg.slots[0].fsm == ttm_pkg::T_WAIT_ACK
		|=> st_reg.slots[0].failed && st_reg.slots[0].fsm == ttm_pkg::T_IDLE && resp.valid
		&& resp.status == ttm_pkg::ST_ACK_ERR)
		else $error("ack error not recorded");

	// Exhausted retries store a substitute entry
	AST_RETRY_LIMIT: assert property (
		link_evt.valid && link_evt.kind == ttm_pkg::EV_ACK_BUSY && link_evt.timer == 3'h2
		&& st_reg.slots[2].fsm == ttm_pkg::T_WAIT_ACK && st_reg.slots[2].retries == RETRY_LIMIT
		|=> resp.valid && resp.dummy && resp.timer == 3'h2 && resp.status == ttm_pkg::ST_RETRY_LIMIT)
		else $error("no substitute entry on retry limit");

	// Aborted transaction goes idle with no entry of its own
	AST_ABORT_SILENT: assert property (
		cancel_hit[0] && !link_evt.valid && st_reg.slots[0].fsm != ttm_pkg::T_IDLE
		|=> st_reg.slots[0].fsm == ttm_pkg::T_IDLE && !(resp.valid && resp.timer == 3'h0))
		else $error("abort left entry or busy timer");

	// A busy answer below the limit bumps the count and resends
	AST_RETRY_COUNT: assert property (
		link_evt.valid && link_evt.kind == ttm_pkg::EV_ACK_BUSY && link_evt.timer == 3'h2
		&& st_reg.slots[2].fsm == ttm_pkg::T_WAIT_ACK && st_reg.slots[2].retries != RETRY_LIMIT
		|=> retry_flag[2] && st_reg.slots[2].retries == $past(st_reg.slots[2].retries) + 4'h1)
		else $error("retry not counted");

	// Busy without retry flag is always the split wait
	AST_SPLIT_VIEW: assert property (
		!retry_flag[3] && st_reg.slots[3].fsm != ttm_pkg::T_IDLE |-> st_reg.slots[3].fsm == ttm_pkg::T_SPLIT)
		else $error("busy timer neither retrying nor split");

	// Attribute read returns the selected timer's tcode and speed
	AST_SELECT_ATTR: assert property (
		arvalid && arready && araddr == ttm_pkg::ATTR_OFS && st_reg.sel == 3'h4
		|=> rvalid && rdata[31:28] == $past(st_reg.slots[4].hdr.tcode)
		&& rdata[26:25] == $past(st_reg.slots[4].hdr.spd))
		else $error("status view not of selected timer");

	// Number five never runs
	AST_UNUSED_TIMER: assert property (
		st_reg.slots[5].fsm == ttm_pkg::T_IDLE)
		else $error("unused timer active");

	// Hold then release goes through the held state back to sending
	AST_HOLD: assert property (
		suspend_hit[1] && !cancel_hit[1] && st_reg.slots[1].fsm == ttm_pkg::T_WAIT_ACK && !link_evt.valid
		|=> st_reg.slots[1].fsm == ttm_pkg::T_HELD)
		else $error("hold ignored");

	AST_RESUME: assert property (
		resume_hit[1] && !cancel_hit[1] && !suspend_hit[1] && !link_evt.valid
		&& st_reg.slots[1].fsm == ttm_pkg::T_HELD |=> st_reg.slots[1].fsm == ttm_pkg::T_SEND)
		else $error("release ignored");

	COV_SPLIT_OK: cover property (st_reg.slots[0].fsm == ttm_pkg::T_SPLIT ##1
		resp.valid && resp.status == ttm_pkg::ST_OK);
	COV_RETRY_LIMIT: cover property (resp.valid && resp.status == ttm_pkg::ST_RETRY_LIMIT);
	COV_SPLIT_TIMEOUT: cover property (resp.valid && resp.status == ttm_pkg::ST_SPLIT_TIMEOUT);
	COV_ABORT: cover property (|cancel_hit ##1 irq);

endmodule
`default_nettype wire

// >>> sim/remote_node.sv
// Far bus node model that acknowledges and answers outgoing requests
`timescale 1ns/100ps
`default_nettype none
module remote_node (
	input wire logic clk_sys,
	input wire ttm_pkg::send_type send,
	input wire ttm_pkg::event_kind_type ack_kind,
	input wire ttm_pkg::event_kind_type resp_kind,
	input wire logic answer_split,
	input wire logic [7:0] delay,
	output ttm_pkg::link_event_type link_evt
);
	logic [2:0] t; // Timer of the request being answered
	// One event pulse after the commanded delay; the idle timer field is inverted
	task automatic pulse(input ttm_pkg::event_kind_type k);
		repeat (delay) @(posedge clk_sys);
		link_evt <= '{1'b1, t, k};
		@(posedge clk_sys);
		link_evt <= '{1'b0, ~t, k};
	endtask
	// Each packet gets one ack; a pending ack may be followed by a response
	initial begin
		link_evt = '0;
		forever begin
			@(posedge clk_sys);
			if (send.valid === 1'b1) begin
				t = send.timer;
				pulse(ack_kind);
				if (ack_kind == ttm_pkg::EV_ACK_PEND && answer_split) begin
					pulse(resp_kind);
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> sim/tb.sv
// Self-checking bench of the transaction timer manager
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic clk_sys, arst_n, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [7:0] awaddr, araddr, delay; // Delay is the far node's answer time
	logic [31:0] wdata, rdata, rd; // Rd keeps the last word read
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rsp;
	logic answer_split;
	ttm_pkg::tx_request_type tx_req;
	ttm_pkg::link_event_type link_evt;
	ttm_pkg::send_type send, last_send;
	ttm_pkg::resp_entry_type resp, last_resp;
	ttm_pkg::event_kind_type ack_kind, resp_kind;
	ttm_pkg::header_type hdr; // Header of the next request
	int n_fail, num_checks, n_resp, n_send, n0, s0;

	localparam int SPLIT_SIM = 20; // Short split wait keeps the run brief
	transaction_timer_manager #(.SPLIT_CYCLES(SPLIT_SIM)) dut (.clk_sys, .arst_n, .awaddr,
		.awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .tx_req, .link_evt,
		.send, .resp, .irq);
	remote_node node (.clk_sys, .send, .ack_kind, .resp_kind, .answer_split, .delay, .link_evt);

	initial begin
		clk_sys = 0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// Count response entries and transmitted packets
	always @(posedge clk_sys) begin
		if (resp.valid === 1'b1) begin
			last_resp = resp;
			n_resp++;
		end
		if (send.valid === 1'b1) begin
			last_send = send;
			n_send++;
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		if (n_fail == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	function automatic logic [31:0] b(input int i);
		return {31'h0, rd[i]};
	endfunction
	// Write; each channel drops valid once its own ready was seen
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rdreg(input logic [7:0] a);
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask
	task automatic start(input logic [2:0] t);
		n0 = n_resp;
		s0 = n_send;
		@(posedge clk_sys);
		tx_req <= '{1'b1, t, hdr};
		@(posedge clk_sys);
		tx_req.valid <= 1'b0;
	endtask
	// Bounded wait for a new response entry; a missing entry counts as a mismatch
	task automatic wait_resp;
		for (int i = 0; i < 300 && n_resp == n0; i++) @(posedge clk_sys);
		check(32'(n_resp - n0), 32'h1);
	endtask
	task automatic far(input ttm_pkg::event_kind_type a, input logic s, input logic [7:0] d);
		ack_kind <= a;
		answer_split <= s;
		delay <= d;
	endtask
	task automatic status_is(input logic [3:0] st, input logic dm);
		check(32'({last_resp.status, last_resp.dummy}), 32'({st, dm}));
	endtask
	task automatic t_reset;
		rdreg(ttm_pkg::CTRL_OFS);
		check(rd, 32'hFA00_0000);
		rdreg(8'h80);
		check(rd | 32'(rsp), 32'(ttm_pkg::AXI_SLVERR));
		wr(8'h80, 32'h0000_0000);
		check(32'(rsp), 32'(ttm_pkg::AXI_SLVERR));
	endtask
	// Every timer number; number five must start nothing
	task automatic t_normal;
		far(ttm_pkg::EV_ACK_DONE, 1'b0, 8'h06);
		for (int i = 0; i < 7; i++) begin
			start(3'(i));
			if (i == 5) begin
				repeat (20) @(posedge clk_sys);
				check(32'(n_send), 32'(s0));
			end else begin
				rdreg(ttm_pkg::CTRL_OFS);
				check(b(31 - i) | b(15 - i) << 1, 32'h2);
				wait_resp;
				check(32'(last_send.hdr === hdr), 32'h1);
				check(32'(last_resp.timer), 32'(i));
				status_is(ttm_pkg::ST_OK, 1'b0);
				rdreg(ttm_pkg::CTRL_OFS);
				check(b(31 - i) | b(23 - i) << 1, 32'h1);
			end
		end
	endtask
	task automatic t_irq;
		check(32'(irq), 32'h0);
		wr(ttm_pkg::IRQ_MASK_OFS, 32'h0000_007F);
		repeat (2) @(posedge clk_sys);
		check(32'(irq), 32'h1);
		rdreg(ttm_pkg::IRQ_MASK_OFS);
		check(rd, 32'h0000_007F);
		rdreg(ttm_pkg::IRQ_STAT_OFS);
		check(rd, 32'h0000_005F);
		repeat (2) @(posedge clk_sys);
		check(32'(irq), 32'h0);
	endtask
	// Busy until the limit, a good transfer clears the fail flag, then an error acknowledge
	task automatic t_busy;
		far(ttm_pkg::EV_ACK_BUSY, 1'b0, 8'h03);
		start(3'h2);
		wait_resp;
		status_is(ttm_pkg::ST_RETRY_LIMIT, 1'b1);
		check(32'(n_send - s0), 32'(ttm_pkg::RETRY_LIMIT_DEF) + 32'h1);
		rdreg(ttm_pkg::CTRL_OFS);
		check(b(21), 32'h1);
		wr(ttm_pkg::CTRL_OFS, 32'h0000_0020);
		rdreg(ttm_pkg::ATTR_OFS);
		check(32'(rd[17:14]), 32'(ttm_pkg::RETRY_LIMIT_DEF));
		far(ttm_pkg::EV_ACK_DONE, 1'b0, 8'h03);
		start(3'h2);
		wait_resp;
		rdreg(ttm_pkg::CTRL_OFS);
		check(b(21), 32'h0);
		far(ttm_pkg::EV_ACK_ERR, 1'b0, 8'h03);
		start(3'h0);
		wait_resp;
		status_is(ttm_pkg::ST_ACK_ERR, 1'b0);
		rdreg(ttm_pkg::CTRL_OFS);
		check(b(23), 32'h1);
	endtask
	// Selected view of a split transaction that ends with an error code, then a split timeout and a good split response
	task automatic t_split;
		far(ttm_pkg::EV_ACK_PEND, 1'b1, 8'h0A);
		resp_kind <= ttm_pkg::EV_RESP_ERR;
		start(3'h4);
		wr(ttm_pkg::CTRL_OFS, 32'h0000_0040);
		rdreg(ttm_pkg::ADDR_HI_OFS);
		check(rd, {hdr.dest_id, hdr.off_hi});
		rdreg(ttm_pkg::ADDR_LO_OFS);
		check(rd, hdr.off_lo);
		rdreg(ttm_pkg::ATTR_OFS);
		check(rd & 32'hFFFF_C000, {hdr.tcode, 1'b0, hdr.spd, 1'b0, hdr.tlabel, 18'h0});
		rdreg(ttm_pkg::CTRL_OFS);
		check(b(27) | b(11), 32'h0);
		wait_resp;
		status_is(ttm_pkg::ST_RCODE_ERR, 1'b0);
		far(ttm_pkg::EV_ACK_PEND, 1'b0, 8'h02);
		start(3'h3);
		wait_resp;
		status_is(ttm_pkg::ST_SPLIT_TIMEOUT, 1'b1);
		wr(ttm_pkg::CTRL_OFS, 32'h0000_0030);
		rdreg(ttm_pkg::ATTR_OFS);
		check(32'(rd[13:0]), 32'(SPLIT_SIM));
		far(ttm_pkg::EV_ACK_PEND, 1'b1, 8'h02);
		resp_kind <= ttm_pkg::EV_RESP_OK;
		start(3'h0);
		wait_resp;
		status_is(ttm_pkg::ST_OK, 1'b0);
	endtask
	// Cancel in mid-flight, suspend and resume, then a bus reset drops a transfer
	task automatic t_abort_hold;
		far(ttm_pkg::EV_ACK_DONE, 1'b0, 8'h28);
		start(3'h0);
		wr(ttm_pkg::CTRL_OFS, 32'h0000_0008);
		repeat (60) @(posedge clk_sys);
		check(32'(n_resp), 32'(n0));
		far(ttm_pkg::EV_ACK_DONE, 1'b0, 8'h1E);
		start(3'h1);
		wr(ttm_pkg::CTRL_OFS, 32'h0000_0014);
		repeat (50) @(posedge clk_sys);
		check(32'(n_resp), 32'(n0));
		wr(ttm_pkg::CTRL_OFS, 32'h0000_0012);
		wait_resp;
		status_is(ttm_pkg::ST_OK, 1'b0);
		check(32'(n_send - s0), 32'h2);
		far(ttm_pkg::EV_BUS_RESET, 1'b0, 8'h03);
		start(3'h0);
		repeat (20) @(posedge clk_sys);
		check(32'(n_resp), 32'(n0));
		rdreg(ttm_pkg::CTRL_OFS);
		check(b(31), 32'h1);
	endtask
	initial begin
		{arst_n, awvalid, wvalid, bready, arvalid, rready, answer_split} = '0;
		{awaddr, araddr, wdata, n_fail, num_checks, n_resp, n_send} = '0;
		wstrb = 4'hF;
		delay = 8'h06;
		tx_req = '0;
		ack_kind = ttm_pkg::EV_ACK_DONE;
		resp_kind = ttm_pkg::EV_RESP_OK;
		hdr = '{16'hFFC5, 16'h00AB, 32'h1234_5678, 4'h5, ttm_pkg::SPD_400, 6'h2D};
		repeat (4) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		t_reset;
		t_normal;
		t_irq;
		t_busy;
		t_split;
		t_abort_hold;
		report_and_stop;
	end
	// Hang guard, well above the few hundred cycles the tests need
	initial begin
		repeat (6000) @(posedge clk_sys);
		n_fail++;
		report_and_stop;
	end
endmodule
`default_nettype wire
